// *** rtl/sts_pkg.sv ***
// Constants for the system timer and ready status block.
// Assumes a single 125 MHz system clock and a host register port.
package sts_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int FREE_HZ = 25_000_000;
  localparam int FREE_DIV = CLK_HZ / FREE_HZ;
  localparam int FR_CLEAR_NS = 160;
  // Longest time, so rounded down
  localparam int FR_CLEAR_CYC = (FR_CLEAR_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int TICK_DEFAULT = 1;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_HARDWARE_CONFIGURATION = 8'h74;
  localparam logic [7:0] OFF_TIMER_CFG = 8'h8c;
  localparam logic [7:0] OFF_TIMER_CNT = 8'h90;
  localparam logic [7:0] OFF_FREE_RUN = 8'h9c;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int READY_BIT = 27;
  localparam int XOVER2_BIT = 26;
  localparam int XOVER1_BIT = 25;
  localparam int TIMER_EN_BIT = 29;
  localparam logic [15:0] PRELOAD_RST = 16'hffff;
  localparam logic [15:0] COUNT_RST = 16'hffff;
  localparam logic [31:0] FREE_RST = 32'h00000000;

endpackage : sts_pkg

// *** rtl/sts_timer_status.sv ***
// Ready flag, crossover strap latch, general purpose timer and free count.
// Assumes a host register port synchronous to clk_sys and strap pins
// that are stable around reset release.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - The ready flag at bit 27 is clear after any reset and is set once the device reports stable.
// - A rising ready flag raises a ready interrupt when its enable is active.
// - The configuration register may be polled in reset or not ready, values in reset being invalid.
// - Either 16-bit half of a register may be read alone.
// - Bits 26 and 25 show the crossover straps of ports 2 and 1, latched at reset and rewritable by the loader.
// - Each port's crossover override control and state replace its latched strap.
// - Timer enable bit 29 runs the timer when set, halts it when clear, and resets to zero.
// - A falling timer enable forces the preload field to all ones.
// - The preload field gives the start value and the running timer counts down one step per tick.
// - The timer raises host interrupts periodically.
// - The count register returns the current timer value in its low half, upper half zero.
// - A 32-bit free count starts at zero and increments on each 25 MHz cycle.
// - The free count wraps from its maximum to zero without any event.
module sts_timer_status #(
  parameter int TICK_CYCLES = sts_pkg::TICK_DEFAULT
) (
  // Clock and resets
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic digital_reset,
  input wire logic device_stable,
  // Straps and loader
  input wire logic strap_xover_1,
  input wire logic strap_xover_2,
  input wire logic eeprom_strap_wr,
  input wire logic [1:0] eeprom_strap_data,
  // PHY crossover overrides, bit 0 is port 1
  input wire logic [1:0] crossover_override_control,
  input wire logic [1:0] crossover_override_state,
  // Host register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_half,
  input wire logic reg_upper,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Interrupt enables and clear
  input wire logic ready_irq_en,
  input wire logic timer_irq_en,
  input wire logic timer_status_clr,
  // Status outputs
  output logic [1:0] crossover_enable_strap_state,
  output logic ready,
  output logic ready_irq,
  output logic timer_status,
  output logic timer_irq
);

  // Refused at elaboration, the prescaler is only 16 bits wide
  if (TICK_CYCLES < 1 || TICK_CYCLES > 65536) begin : g_tick_chk
    $error("TICK_CYCLES out of range");
  end

  localparam int FR_LIM = sts_pkg::FR_CLEAR_CYC;

  logic next_ready;
  logic strap_pending;
  logic [1:0] strap_latch;
  logic cfg_wr;
  logic timer_en;
  logic [15:0] preload;
  logic [15:0] count;
  logic [15:0] tick_cnt;
  logic tick;
  logic [2:0] div_cnt;
  logic fr_tick;
  logic [31:0] free_count;
  logic [31:0] rd_word;

  // ----------------------------------------
  // Ready flag
  // ----------------------------------------
  always_comb begin
    next_ready = ready;
    if (digital_reset) begin
      next_ready = 1'b0;
    end else if (device_stable) begin
      next_ready = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ready <= 1'b0;
      ready_irq <= 1'b0;
    end else begin
      ready <= next_ready;
      ready_irq <= ready_irq_en & ~ready & next_ready;
    end
  end

  // ----------------------------------------
  // Crossover straps
  // ----------------------------------------
  // Pins are caught on the first edge after release, never by the reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      strap_pending <= 1'b1;
      strap_latch <= 2'h0;
    end else if (digital_reset) begin
      strap_pending <= 1'b1;
    end else if (strap_pending) begin
      strap_pending <= 1'b0;
      strap_latch <= {strap_xover_2, strap_xover_1};
    end else if (eeprom_strap_wr) begin
      strap_latch <= eeprom_strap_data;
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_port
    assign crossover_enable_strap_state[p] = crossover_override_control[p]
        ? crossover_override_state[p] : strap_latch[p];
  end

  // ----------------------------------------
  // General purpose timer
  // ----------------------------------------
  // Writes before ready are dropped so a half-booted host cannot start it
  assign cfg_wr = reg_wr & ready & (reg_addr == sts_pkg::OFF_TIMER_CFG);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      timer_en <= 1'b0;
      preload <= sts_pkg::PRELOAD_RST;
    end else if (digital_reset) begin
      timer_en <= 1'b0;
      preload <= sts_pkg::PRELOAD_RST;
    end else if (cfg_wr) begin
      timer_en <= reg_wdata[sts_pkg::TIMER_EN_BIT];
      if (timer_en && !reg_wdata[sts_pkg::TIMER_EN_BIT]) begin
        preload <= sts_pkg::PRELOAD_RST;
      end else begin
        preload <= reg_wdata[15:0];
      end
    end
  end

  assign tick = timer_en & (tick_cnt == 16'(TICK_CYCLES - 1));

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt <= 16'h0000;
    end else if (digital_reset || cfg_wr || tick || !timer_en) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count <= sts_pkg::COUNT_RST;
    end else if (digital_reset) begin
      count <= sts_pkg::COUNT_RST;
    end else if (cfg_wr && reg_wdata[sts_pkg::TIMER_EN_BIT]) begin
      count <= reg_wdata[15:0];
    end else if (tick) begin
      count <= count - 16'h0001;
    end
  end

  // Set wins over a host clear in the same cycle, a soft reset wins over both
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      timer_status <= 1'b0;
    end else if (digital_reset) begin
      timer_status <= 1'b0;
    end else if (tick && count == 16'h0000) begin
      timer_status <= 1'b1;
    end else if (timer_status_clr) begin
      timer_status <= 1'b0;
    end
  end

  assign timer_irq = timer_status & timer_irq_en;

  // ----------------------------------------
  // Free running counter
  // ----------------------------------------
  assign fr_tick = (div_cnt == 3'(sts_pkg::FREE_DIV - 1));

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt <= 3'h0;
      free_count <= sts_pkg::FREE_RST;
    end else if (digital_reset) begin
      div_cnt <= 3'h0;
      free_count <= sts_pkg::FREE_RST;
    end else begin
      div_cnt <= fr_tick ? 3'h0 : div_cnt + 3'h1;
      if (fr_tick) begin
        free_count <= free_count + 32'h00000001;
      end
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always_comb begin
    rd_word = 32'h00000000;
    unique case (reg_addr)
      sts_pkg::OFF_HARDWARE_CONFIGURATION: begin
        rd_word[sts_pkg::READY_BIT] = ready;
        rd_word[sts_pkg::XOVER2_BIT] = crossover_enable_strap_state[1];
        rd_word[sts_pkg::XOVER1_BIT] = crossover_enable_strap_state[0];
      end
      sts_pkg::OFF_TIMER_CFG: begin
        rd_word[sts_pkg::TIMER_EN_BIT] = timer_en;
        rd_word[15:0] = preload;
      end
      sts_pkg::OFF_TIMER_CNT: rd_word[15:0] = count;
      sts_pkg::OFF_FREE_RUN: rd_word = free_count;
      default: rd_word = 32'h00000000;
    endcase
    // Only the configuration register answers before ready
    if (!ready && reg_addr != sts_pkg::OFF_HARDWARE_CONFIGURATION) begin
      rd_word = 32'h00000000;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h00000000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        if (reg_half) begin
          reg_rdata <= {16'h0000, reg_upper ? rd_word[31:16]
                                            : rd_word[15:0]};
        end else begin
          reg_rdata <= rd_word;
        end
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence tmr_tick_s;
    tick && !digital_reset && !cfg_wr;
  endsequence

  sequence tmr_zero_tick_s;
    tmr_tick_s and (count == 16'h0000);
  endsequence

  sequence tmr_fall_s;
    timer_en ##1 !timer_en && !digital_reset;
  endsequence

  ready_clear_a: assert property (digital_reset |=> !ready)
    else $error("ready not cleared by digital reset");

  ready_irq_a: assert property ($rose(ready) |-> ready_irq == $past(ready_irq_en))
    else $error("ready interrupt mismatch");

  half_read_a: assert property (reg_rd && reg_half |=> reg_rvalid && reg_rdata[31:16] == 16'h0000)
    else $error("half read upper bits not zero");

  strap_read_a: assert property (reg_rd && !reg_half && ready && reg_addr == sts_pkg::OFF_HARDWARE_CONFIGURATION |=> reg_rdata[26:25] == $past(crossover_enable_strap_state))
    else $error("strap bits wrong in read");

  xover_override_a: assert property (crossover_override_control[1] |-> crossover_enable_strap_state[1] == crossover_override_state[1])
    else $error("crossover override ignored");

  timer_halt_a: assert property (!timer_en && !cfg_wr && !digital_reset |=> $stable(count))
    else $error("halted timer moved");

  preload_fall_a: assert property (tmr_fall_s |-> preload == 16'hffff)
    else $error("preload not forced on disable");

  count_step_a: assert property (tmr_tick_s |=> count == $past(count) - 16'h0001)
    else $error("timer did not step down by one");

  count_read_a: assert property (reg_rd && !reg_half && ready && reg_addr == sts_pkg::OFF_TIMER_CNT |=> reg_rdata == {16'h0000, $past(count)})
    else $error("count read mismatch");

  free_inc_a: assert property (fr_tick && !digital_reset |=> free_count == $past(free_count) + 32'h00000001)
    else $error("free count did not advance");

  // A soft reset restarts the divider, so a pending gap check is dropped
  free_pace_a: assert property (disable iff (!reset_n || digital_reset)
      fr_tick |=> !fr_tick [*4] ##1 fr_tick)
    else $error("free count not at 25 MHz");

  free_clear_a: assert property (digital_reset |-> ##[1:FR_LIM] free_count == 32'h00000000)
    else $error("free count not cleared in time");

  timer_wrap_a: assert property (tmr_zero_tick_s |=> timer_status && count == 16'hffff)
    else $error("timer wrap not flagged");

endmodule : sts_timer_status

`default_nettype wire

// *** testbench/sts_host_model.sv ***
// Host model that reaches the timer and status registers.
// Assumes one clock; drives at falling edges, samples after the answer.
`timescale 1ns/1ps
`default_nettype none
module sts_host_model (
  // Clock and status
  input wire logic clk_sys,
  input wire logic ready,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic reg_half,
  output logic reg_upper,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata
);
  int edge_no = 0;
  int took = 0;
  logic trusted;
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_half = 1'b0;
    reg_upper = 1'b0;
    reg_wdata = 32'h00000000;
  end
  always @(posedge clk_sys) edge_no <= edge_no + 1;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    took = edge_no;
    reg_wr = 1'b0;
    // Released lines flip so a stale value is never mistaken for data
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic hf, input logic up,
                    output logic [31:0] v);
    @(negedge clk_sys);
    reg_addr = a;
    reg_half = hf;
    reg_upper = up;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    took = edge_no;
    reg_rd = 1'b0;
    reg_addr = ~a;
    // Only the configuration register means anything before ready
    trusted = ready || (a == 8'h74);
    v = reg_rdata;
  endtask : rd
endmodule : sts_host_model
`default_nettype wire

// *** testbench/sts_timer_status_tb.sv ***
// Self-checking bench for the timer and ready status block.
// Assumes a short timer tick so that a wrap fits a brief run.
`timescale 1ns/1ps
`default_nettype none
module sts_timer_status_tb;
  logic clk_sys = 1'b0, reset_n = 1'b0, digital_reset = 1'b0;
  logic device_stable = 1'b0, strap_xover_1 = 1'b1, strap_xover_2 = 1'b0;
  logic eeprom_strap_wr = 1'b0, ready_irq_en = 1'b1, timer_irq_en = 1'b1;
  logic timer_status_clr = 1'b0, reg_wr, reg_rd, reg_half, reg_upper;
  logic [1:0] eeprom_strap_data = 2'h0, ovc = 2'h0, ovs = 2'h0, eff;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, seed = 32'h18b2eee4, r, a, b;
  logic reg_rvalid, ready, ready_irq, timer_status, timer_irq;
  logic [15:0] p;
  int err_total = 0, checked = 0, w, n;
  always #4 clk_sys = ~clk_sys;
  sts_timer_status #(.TICK_CYCLES(1)) sts_timer_status_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .digital_reset(digital_reset),
    .device_stable(device_stable), .strap_xover_1(strap_xover_1),
    .strap_xover_2(strap_xover_2), .eeprom_strap_wr(eeprom_strap_wr),
    .eeprom_strap_data(eeprom_strap_data),
    .crossover_override_control(ovc), .crossover_override_state(ovs),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_half(reg_half), .reg_upper(reg_upper), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .ready_irq_en(ready_irq_en), .timer_irq_en(timer_irq_en),
    .timer_status_clr(timer_status_clr),
    .crossover_enable_strap_state(eff), .ready(ready),
    .ready_irq(ready_irq), .timer_status(timer_status),
    .timer_irq(timer_irq));
  sts_host_model sts_host_model_inst (.clk_sys(clk_sys), .ready(ready),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_half(reg_half), .reg_upper(reg_upper), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic rdc(input string nm, input logic [7:0] ad,
                     input logic hf, up, input logic [31:0] e);
    logic [31:0] v;
    sts_host_model_inst.rd(ad, hf, up, v);
    chk(nm, v, e);
    chk("rvalid", {31'h0, reg_rvalid}, 32'h00000001);
  endtask : rdc
  task automatic close_out();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  initial begin
    #160000;
    err_total++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys) reset_n = 1'b1;
    // --------------------------------
    // Not ready: only the config reads
    // --------------------------------
    rdc("hardware_configuration", 8'h74, 1'b0, 1'b0, 32'h02000000);
    sts_host_model_inst.wr(8'h8c, 32'h20000005);
    rdc("cfg_refused", 8'h8c, 1'b0, 1'b0, 32'h00000000);
    $display("test not_ready done");
    // --------------------------------
    // Ready and reset values
    // --------------------------------
    @(negedge clk_sys) device_stable = 1'b1;
    n = 0;
    repeat (4) @(negedge clk_sys) n += int'(ready_irq === 1'b1);
    chk("ready_irq", n, 1);
    rdc("hardware_configuration_rdy", 8'h74, 1'b0, 1'b0, 32'h0a000000);
    rdc("hw_hi", 8'h74, 1'b1, 1'b1, 32'h00000a00);
    rdc("hw_lo", 8'h74, 1'b1, 1'b0, 32'h00000000);
    rdc("cfg_rst", 8'h8c, 1'b0, 1'b0, 32'h0000ffff);
    rdc("cnt_rst", 8'h90, 1'b0, 1'b0, 32'h0000ffff);
    rdc("unmapped", 8'h00, 1'b0, 1'b0, 32'h00000000);
    $display("test ready done");
    // --------------------------------
    // Straps, loader and overrides
    // --------------------------------
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      @(negedge clk_sys);
      eeprom_strap_data = r[5:4];
      eeprom_strap_wr = 1'b1;
      ovc = r[1:0];
      ovs = r[3:2];
      @(negedge clk_sys) eeprom_strap_wr = 1'b0;
      a = {30'h0, (ovc & ovs) | (~ovc & r[5:4])};
      chk("strap_out", {30'h0, eff}, a);
      rdc("hw_strap", 8'h74, 1'b0, 1'b0, 32'h08000000 | (a << 25));
    end
    $display("test straps done");
    // --------------------------------
    // Timer count, wrap and status
    // --------------------------------
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      p = {13'h0, r[2:0]};
      sts_host_model_inst.wr(8'h8c, {16'h2000, p});
      w = sts_host_model_inst.took;
      repeat (r[4:3]) @(negedge clk_sys);
      sts_host_model_inst.rd(8'h90, 1'b0, 1'b0, a);
      p = p - 16'(sts_host_model_inst.took - w - 1);
      chk("count", a, {16'h0, p});
      repeat (10) @(negedge clk_sys);
      chk("status", {31'h0, timer_status}, 32'h00000001);
      chk("timer_irq", {31'h0, timer_irq}, 32'h00000001);
      @(negedge clk_sys) timer_irq_en = 1'b0;
      @(negedge clk_sys);
      chk("irq_masked", {31'h0, timer_irq}, 32'h00000000);
      @(negedge clk_sys) begin
        timer_status_clr = 1'b1;
        timer_irq_en = 1'b1;
      end
      @(negedge clk_sys) timer_status_clr = 1'b0;
      chk("status_clr", {31'h0, timer_status}, 32'h00000000);
    end
    sts_host_model_inst.wr(8'h8c, 32'h00000003);
    rdc("preload_ones", 8'h8c, 1'b0, 1'b0, 32'h0000ffff);
    sts_host_model_inst.rd(8'h90, 1'b0, 1'b0, a);
    rdc("halted", 8'h90, 1'b0, 1'b0, a);
    $display("test timer done");
    // --------------------------------
    // Free count and soft reset
    // --------------------------------
    sts_host_model_inst.rd(8'h9c, 1'b0, 1'b0, a);
    repeat (23) @(negedge clk_sys);
    sts_host_model_inst.rd(8'h9c, 1'b0, 1'b0, b);
    chk("free_step", b - a, 32'h00000005);
    @(negedge clk_sys) begin
      digital_reset = 1'b1;
      ready_irq_en = 1'b0;
    end
    @(negedge clk_sys) digital_reset = 1'b0;
    chk("ready_soft", {31'h0, ready}, 32'h00000000);
    n = 0;
    // Counter needs a short settle after reset
    repeat (sts_pkg::FR_CLEAR_CYC) @(negedge clk_sys) n += int'(ready_irq === 1'b1);
    chk("ready_irq_masked", n, 0);
    sts_host_model_inst.rd(8'h9c, 1'b0, 1'b0, a);
    chk("free_clear", {31'h0, a < 32'h8}, 32'h00000001);
    rdc("cnt_soft", 8'h90, 1'b0, 1'b0, 32'h0000ffff);
    $display("test free done");
    close_out();
  end
endmodule : sts_timer_status_tb
`default_nettype wire
